// ### inc/clk_ctrl_pkg.sv
// Constants and types for the peripheral, radio and system clock control block
package clk_ctrl_pkg;

  // Register offsets
  localparam logic [31:0] PERIPH_CLK_OFFSET  = 32'h5000_0004;
  localparam logic [31:0] RADIO_CLK_OFFSET   = 32'h5000_0008;
  localparam logic [31:0] SYS_CLK_OFFSET     = 32'h5000_000a;

  // Reset values
  localparam logic [15:0] PERIPH_CLK_RESET   = 16'h0000;
  localparam logic [15:0] RADIO_CLK_RESET    = 16'h0040;
  localparam logic [15:0] SYS_CLK_RESET      = 16'h0000;

  // Writable bit masks, every other bit reads as zero except the system clock status bits 7 to 5
  localparam logic [15:0] PERIPH_CLK_MASK    = 16'h8bfb;
  localparam logic [15:0] RADIO_CLK_MASK     = 16'h00fb;
  localparam logic [15:0] SYS_CLK_MASK       = 16'h000f;

  // Peripheral clock register fields
  localparam int QUAD_GATE_BIT               = 15;
  localparam int SPI_GATE_BIT                = 11;
  localparam int SPI_DIV_LSB                 = 8;
  localparam int FIRST_UART_GATE_BIT         = 7;
  localparam int SECOND_UART_GATE_BIT        = 6;
  localparam int I2C_GATE_BIT                = 5;
  localparam int WAKE_CAPTURE_GATE_BIT       = 4;
  localparam int TIMERS_GATE_BIT             = 3;
  localparam int TIMER_ZERO_DIV_LSB          = 0;

  // Radio clock register fields
  localparam int LINK_CORE_GATE_BIT          = 7;
  localparam int LP_TIMER_RESET_BIT          = 6;
  localparam int LINK_CORE_DIV_LSB           = 4;
  localparam int RF_CTRL_GATE_BIT            = 3;
  localparam int RF_CTRL_DIV_LSB             = 0;

  // System clock register fields
  localparam int CRYSTAL_ACTIVE_BIT          = 7;
  localparam int FAST_RC_ACTIVE_BIT          = 6;
  localparam int SLOW_ACTIVE_BIT             = 5;
  localparam int SPIKE_BYPASS_BIT            = 3;
  localparam int CRYSTAL_OFF_BIT             = 2;
  localparam int SOURCE_SEL_LSB              = 0;

  // Divider counter width, enough for divide by 8
  localparam int DIV_CNT_WIDTH               = 3;

  // System clock source codes
  localparam logic [1:0] SRC_CRYSTAL         = 2'h0;
  localparam logic [1:0] SRC_FAST_RC         = 2'h1;
  localparam logic [1:0] SRC_SLOW            = 2'h2;

  // Source switch states, Gray coded
  typedef enum logic [1:0] {
    RUN_CRYSTAL  = 2'b00,
    RUN_FAST_RC  = 2'b01,
    RUN_SLOW     = 2'b11,
    WAIT_CRYSTAL = 2'b10
  } src_state_type;

endpackage

// ### hw/periph_radio_sysclk_ctrl.sv
// Peripheral, radio and system clock source control block
`timescale 1ns/100ps

module periph_radio_sysclk_ctrl
  import clk_ctrl_pkg::*;
#(
  parameter int ADDR_WIDTH = 32,
  parameter int DATA_WIDTH = 16
)
(
  // Clock and reset
  input  wire logic                  ref_clk,
  input  wire logic                  nrst,
  // Register port
  input  wire logic [ADDR_WIDTH-1:0] regAddr,
  input  wire logic [DATA_WIDTH-1:0] regWrData,
  input  wire logic                  regWrStrobe,
  input  wire logic                  regRdStrobe,
  output logic      [DATA_WIDTH-1:0] regRdData,
  // Oscillator status pins
  input  wire logic                  crystalSettledPin,
  input  wire logic                  crystalTrimDonePin,
  input  wire logic                  sleepActivePin,
  // Peripheral clock enables
  output logic                       quadClkEn,
  output logic                       firstUartClkEn,
  output logic                       secondUartClkEn,
  output logic                       i2cClkEn,
  output logic                       spiClkEn,
  output logic                       wakeCaptureClkEn,
  output logic                       timersClkEn,
  output logic                       timerZeroClkEn,
  // Radio clock enables and reset
  output logic                       linkCoreClkEn,
  output logic                       rfCtrlClkEn,
  output logic                       lpTimerReset,
  // Oscillator and system clock controls
  output logic                       crystalOscEn,
  output logic                       spikeFilterBypass,
  output logic      [1:0]            systemClockSource
);

  // Elaboration checks: the decoder compares exactly 32 address bits
  if (ADDR_WIDTH != 32)
  begin
    $error("periph_radio_sysclk_ctrl: address must be 32 bits");
  end
  // Registers are 16 bits wide
  if (DATA_WIDTH < 16)
  begin
    $error("periph_radio_sysclk_ctrl: data must be at least 16 bits");
  end
  // The divide-by-8 tick reads three counter bits
  if (DIV_CNT_WIDTH < 3)
  begin
    $error("periph_radio_sysclk_ctrl: divider counter needs at least 3 bits");
  end

  typedef struct packed {
    logic [15:0]              periphReg;
    logic [15:0]              radioReg;
    logic [15:0]              sysReg;
    src_state_type            srcState;
    logic [DIV_CNT_WIDTH-1:0] divCnt;
    logic                     settledMeta;
    logic                     settledSync;
    logic                     trimMeta;
    logic                     trimSync;
    logic                     sleepMeta;
    logic                     sleepSync;
    logic [DATA_WIDTH-1:0]    rdData;
    logic                     quadEn;
    logic                     firstUartEn;
    logic                     secondUartEn;
    logic                     i2cEn;
    logic                     spiEn;
    logic                     wakeCaptureEn;
    logic                     timersEn;
    logic                     timerZeroEn;
    logic                     linkCoreEn;
    logic                     rfCtrlEn;
    logic                     lpReset;
    logic                     crystalEn;
    logic                     spikeBypass;
    logic [1:0]               activeSrc;
  } ctrl_state_type;

  ctrl_state_type st_r;
  ctrl_state_type st_nxt;

  // Divide-by-2^sel tick: counter low bits all ones
  function automatic logic divTick(input logic [DIV_CNT_WIDTH-1:0] cnt, input logic [1:0] sel);
    logic res;
    res = 1'b1;
    case (sel)
      2'h0:    res = 1'b1;
      2'h1:    res = cnt[0];
      2'h2:    res = &cnt[1:0];
      2'h3:    res = &cnt[2:0];
      default: res = 1'b1;
    endcase
    return res;
  endfunction

  // Status flags derived from the source state
  function automatic logic [15:0] statusBits(input src_state_type s);
    logic [15:0] res;
    res = 16'h0000;
    res[CRYSTAL_ACTIVE_BIT] = (s == RUN_CRYSTAL);
    res[FAST_RC_ACTIVE_BIT] = (s == RUN_FAST_RC);
    res[SLOW_ACTIVE_BIT]    = (s == RUN_SLOW);
    return res;
  endfunction

  // One-hot register select from the byte address, shared by writes and reads
  function automatic logic [2:0] regSelect(input logic [31:0] addr);
    logic [2:0] res;
    res = 3'h0;
    if (addr == PERIPH_CLK_OFFSET)
    begin
      res[0] = 1'b1;
    end
    if (addr == RADIO_CLK_OFFSET)
    begin
      res[1] = 1'b1;
    end
    if (addr == SYS_CLK_OFFSET)
    begin
      res[2] = 1'b1;
    end
    return res;
  endfunction

  // Crystal usable once oscillating and settled or trimmed
  logic        crystalReady;
  logic [1:0]  srcSel;
  logic        crystalOff;
  logic        wrPeriph;
  logic        wrRadio;
  logic        wrSys;
  logic [15:0] wrWord;
  logic [2:0]  regSel;

  always_comb
  begin
    st_nxt       = st_r;
    wrWord       = regWrData[15:0];
    regSel       = regSelect(regAddr[31:0]);
    wrPeriph     = regWrStrobe && regSel[0];
    wrRadio      = regWrStrobe && regSel[1];
    wrSys        = regWrStrobe && regSel[2];
    crystalReady = 1'b0;
    srcSel       = 2'h0;
    crystalOff   = 1'b0;

    // Pin synchronisers
    st_nxt.settledMeta = crystalSettledPin;
    st_nxt.settledSync = st_r.settledMeta;
    st_nxt.trimMeta    = crystalTrimDonePin;
    st_nxt.trimSync    = st_r.trimMeta;
    st_nxt.sleepMeta   = sleepActivePin;
    st_nxt.sleepSync   = st_r.sleepMeta;

    // Register writes, unused bits masked off
    if (wrPeriph)
    begin
      st_nxt.periphReg = wrWord & PERIPH_CLK_MASK;
    end
    if (wrRadio)
    begin
      st_nxt.radioReg = wrWord & RADIO_CLK_MASK;
    end
    if (wrSys)
    begin
      st_nxt.sysReg = wrWord & SYS_CLK_MASK;
    end

    // Register reads, data one cycle later
    st_nxt.rdData = '0;
    if (regRdStrobe)
    begin
      case (regSel)
        3'h1:
        begin
          st_nxt.rdData[15:0] = st_r.periphReg;
        end
        3'h2:
        begin
          st_nxt.rdData[15:0] = st_r.radioReg;
        end
        3'h4:
        begin
          st_nxt.rdData[15:0] = st_r.sysReg | statusBits(st_r.srcState);
        end
        default:
        begin
          st_nxt.rdData = '0;
        end
      endcase
    end

    // Free-running divider counter
    st_nxt.divCnt = st_r.divCnt + DIV_CNT_WIDTH'(1);

    // Peripheral clock gates
    st_nxt.quadEn        = st_r.periphReg[QUAD_GATE_BIT];
    st_nxt.firstUartEn   = st_r.periphReg[FIRST_UART_GATE_BIT];
    st_nxt.secondUartEn  = st_r.periphReg[SECOND_UART_GATE_BIT];
    st_nxt.i2cEn         = st_r.periphReg[I2C_GATE_BIT];
    st_nxt.wakeCaptureEn = st_r.periphReg[WAKE_CAPTURE_GATE_BIT];
    st_nxt.timersEn      = st_r.periphReg[TIMERS_GATE_BIT];
    st_nxt.spiEn         = st_r.periphReg[SPI_GATE_BIT]
                           && divTick(st_r.divCnt, st_r.periphReg[SPI_DIV_LSB +: 2]);
    st_nxt.timerZeroEn   = st_r.periphReg[TIMERS_GATE_BIT]
                           && divTick(st_r.divCnt, st_r.periphReg[TIMER_ZERO_DIV_LSB +: 2]);

    // Radio clock gates and low-power timer reset
    st_nxt.linkCoreEn = st_r.radioReg[LINK_CORE_GATE_BIT]
                        && divTick(st_r.divCnt, st_r.radioReg[LINK_CORE_DIV_LSB +: 2]);
    st_nxt.rfCtrlEn   = st_r.radioReg[RF_CTRL_GATE_BIT]
                        && divTick(st_r.divCnt, st_r.radioReg[RF_CTRL_DIV_LSB +: 2]);
    st_nxt.lpReset    = st_r.radioReg[LP_TIMER_RESET_BIT];

    // Crystal oscillator control; the write itself stops it without waiting
    crystalOff = st_r.sysReg[CRYSTAL_OFF_BIT];
    if (wrSys)
    begin
      crystalOff = wrWord[CRYSTAL_OFF_BIT];
    end
    st_nxt.crystalEn   = !crystalOff && !st_r.sleepSync;
    st_nxt.spikeBypass = st_r.sysReg[SPIKE_BYPASS_BIT];

    // System clock source switching
    crystalReady = st_r.crystalEn && (st_r.settledSync || st_r.trimSync);
    srcSel       = st_r.sysReg[SOURCE_SEL_LSB +: 2];
    case (st_r.srcState)
      RUN_CRYSTAL:
      begin
        if (srcSel == SRC_FAST_RC)
        begin
          st_nxt.srcState = RUN_FAST_RC;
        end
        else if (srcSel[1])
        begin
          st_nxt.srcState = RUN_SLOW;
        end
      end
      RUN_FAST_RC:
      begin
        if (srcSel[1])
        begin
          st_nxt.srcState = RUN_SLOW;
        end
        else if (srcSel == SRC_CRYSTAL)
        begin
          st_nxt.srcState = crystalReady ? RUN_CRYSTAL : WAIT_CRYSTAL;
        end
      end
      RUN_SLOW:
      begin
        if (srcSel == SRC_FAST_RC)
        begin
          st_nxt.srcState = RUN_FAST_RC;
        end
        else if (srcSel == SRC_CRYSTAL)
        begin
          st_nxt.srcState = crystalReady ? RUN_CRYSTAL : WAIT_CRYSTAL;
        end
      end
      WAIT_CRYSTAL:
      begin
        if (srcSel == SRC_FAST_RC)
        begin
          st_nxt.srcState = RUN_FAST_RC;
        end
        else if (srcSel[1])
        begin
          st_nxt.srcState = RUN_SLOW;
        end
        else if (crystalReady)
        begin
          st_nxt.srcState = RUN_CRYSTAL;
        end
      end
      default:
      begin
        st_nxt.srcState = RUN_CRYSTAL;
      end
    endcase

    case (st_nxt.srcState)
      RUN_FAST_RC:  st_nxt.activeSrc = SRC_FAST_RC;
      RUN_SLOW:     st_nxt.activeSrc = SRC_SLOW;
      WAIT_CRYSTAL: st_nxt.activeSrc = st_r.activeSrc;
      default:      st_nxt.activeSrc = SRC_CRYSTAL;
    endcase
  end

  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      st_r.periphReg     <= PERIPH_CLK_RESET;
      st_r.radioReg      <= RADIO_CLK_RESET;
      st_r.sysReg        <= SYS_CLK_RESET;
      st_r.srcState      <= RUN_CRYSTAL;
      st_r.divCnt        <= '0;
      st_r.settledMeta   <= 1'b0;
      st_r.settledSync   <= 1'b0;
      st_r.trimMeta      <= 1'b0;
      st_r.trimSync      <= 1'b0;
      st_r.sleepMeta     <= 1'b0;
      st_r.sleepSync     <= 1'b0;
      st_r.rdData        <= '0;
      st_r.quadEn        <= 1'b0;
      st_r.firstUartEn   <= 1'b0;
      st_r.secondUartEn  <= 1'b0;
      st_r.i2cEn         <= 1'b0;
      st_r.spiEn         <= 1'b0;
      st_r.wakeCaptureEn <= 1'b0;
      st_r.timersEn      <= 1'b0;
      st_r.timerZeroEn   <= 1'b0;
      st_r.linkCoreEn    <= 1'b0;
      st_r.rfCtrlEn      <= 1'b0;
      st_r.lpReset       <= RADIO_CLK_RESET[LP_TIMER_RESET_BIT];
      st_r.crystalEn     <= 1'b1;
      st_r.spikeBypass   <= 1'b0;
      st_r.activeSrc     <= SRC_CRYSTAL;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  // Outputs straight from the state flops
  assign regRdData         = st_r.rdData;
  assign quadClkEn         = st_r.quadEn;
  assign firstUartClkEn    = st_r.firstUartEn;
  assign secondUartClkEn   = st_r.secondUartEn;
  assign i2cClkEn          = st_r.i2cEn;
  assign spiClkEn          = st_r.spiEn;
  assign wakeCaptureClkEn  = st_r.wakeCaptureEn;
  assign timersClkEn       = st_r.timersEn;
  assign timerZeroClkEn    = st_r.timerZeroEn;
  assign linkCoreClkEn     = st_r.linkCoreEn;
  assign rfCtrlClkEn       = st_r.rfCtrlEn;
  assign lpTimerReset      = st_r.lpReset;
  assign crystalOscEn      = st_r.crystalEn;
  assign spikeFilterBypass = st_r.spikeBypass;
  assign systemClockSource = st_r.activeSrc;

endmodule

// ### tb/periph_radio_sysclk_ctrl_chk.sv
// Assertion checker for the clock control block
`timescale 1ns/100ps
module periph_radio_sysclk_ctrl_chk
  import clk_ctrl_pkg::*;
#(
  parameter int ADDR_WIDTH = 32,
  parameter int DATA_WIDTH = 16
)
(
  // Clock, reset and register port
  input wire logic                  ref_clk,
  input wire logic                  nrst,
  input wire logic [ADDR_WIDTH-1:0] regAddr,
  input wire logic [DATA_WIDTH-1:0] regWrData,
  input wire logic                  regWrStrobe,
  input wire logic                  regRdStrobe,
  input wire logic [DATA_WIDTH-1:0] regRdData,
  // Clock enables and controls
  input wire logic                  quadClkEn,
  input wire logic                  firstUartClkEn,
  input wire logic                  secondUartClkEn,
  input wire logic                  i2cClkEn,
  input wire logic                  spiClkEn,
  input wire logic                  wakeCaptureClkEn,
  input wire logic                  timersClkEn,
  input wire logic                  timerZeroClkEn,
  input wire logic                  linkCoreClkEn,
  input wire logic                  rfCtrlClkEn,
  input wire logic                  lpTimerReset,
  input wire logic                  crystalOscEn,
  input wire logic                  spikeFilterBypass,
  input wire logic [1:0]            systemClockSource
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  logic wrPer;
  logic wrRad;
  logic wrSys;
  logic rdMapped;
  assign wrPer = regWrStrobe && (regAddr == PERIPH_CLK_OFFSET);
  assign wrRad = regWrStrobe && (regAddr == RADIO_CLK_OFFSET);
  assign wrSys = regWrStrobe && (regAddr == SYS_CLK_OFFSET);
  assign rdMapped = (regAddr == PERIPH_CLK_OFFSET) || (regAddr == RADIO_CLK_OFFSET) || (regAddr == SYS_CLK_OFFSET);

  property p_quad; wrPer |-> ##2 quadClkEn == $past(regWrData[15], 2); endproperty
  a_quad: assert property (p_quad) else $error("quadrature gate wrong");
  property p_gates;
    wrPer |-> ##2 {firstUartClkEn, secondUartClkEn, i2cClkEn, wakeCaptureClkEn, timersClkEn} == $past(regWrData[7:3], 2);
  endproperty
  a_gates: assert property (p_gates) else $error("peripheral gates wrong");
  property p_spiOff; wrPer && !regWrData[11] |-> ##2 !spiClkEn; endproperty
  a_spiOff: assert property (p_spiOff) else $error("serial clock not stopped");
  property p_tmrFull; wrPer && regWrData[3] && regWrData[1:0] == 2'h0 |-> ##2 timerZeroClkEn; endproperty
  a_tmrFull: assert property (p_tmrFull) else $error("timer zero not divide by one");
  property p_linkOff; wrRad && !regWrData[7] |-> ##2 !linkCoreClkEn; endproperty
  a_linkOff: assert property (p_linkOff) else $error("link core clock not stopped");
  property p_lpRst; wrRad |-> ##2 lpTimerReset == $past(regWrData[6], 2); endproperty
  a_lpRst: assert property (p_lpRst) else $error("low power timer reset wrong");
  property p_rfOff; wrRad && !regWrData[3] |-> ##2 !rfCtrlClkEn; endproperty
  a_rfOff: assert property (p_rfOff) else $error("rf control clock not stopped");
  property p_bypass; wrSys |-> ##2 spikeFilterBypass == $past(regWrData[3], 2); endproperty
  a_bypass: assert property (p_bypass) else $error("spike filter bypass wrong");
  property p_xOff; wrSys && regWrData[2] |=> !crystalOscEn; endproperty
  a_xOff: assert property (p_xOff) else $error("crystal not stopped at once");
  property p_src;
    wrSys && regWrData[1:0] != SRC_CRYSTAL |-> ##2 systemClockSource == ($past(regWrData[1], 2) ? SRC_SLOW : SRC_FAST_RC);
  endproperty
  a_src: assert property (p_src) else $error("system clock source wrong");
  property p_unmapped; regRdStrobe && !rdMapped |=> regRdData == 16'h0; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
endmodule

// ### tb/periph_radio_sysclk_ctrl_tb_top.sv
// Self-checking testbench for the clock control block
`timescale 1ns/100ps
module periph_radio_sysclk_ctrl_tb_top
  import clk_ctrl_pkg::*;
;
  localparam logic [31:0] PER = PERIPH_CLK_OFFSET;
  localparam logic [31:0] RAD = RADIO_CLK_OFFSET;
  localparam logic [31:0] SYS = SYS_CLK_OFFSET;
  logic        ref_clk = 1'b0;
  logic        nrst = 1'b0;
  logic [31:0] regAddr = 32'h0;
  logic [15:0] regWrData = 16'h0;
  logic [15:0] regRdData;
  logic        regWrStrobe = 1'b0;
  logic        regRdStrobe = 1'b0;
  logic        crystalSettledPin = 1'b0;
  logic        crystalTrimDonePin = 1'b0;
  logic        sleepActivePin = 1'b0;
  logic        quadClkEn, firstUartClkEn, secondUartClkEn, i2cClkEn, spiClkEn, wakeCaptureClkEn;
  logic        timersClkEn, timerZeroClkEn, linkCoreClkEn, rfCtrlClkEn, lpTimerReset, crystalOscEn;
  logic        spikeFilterBypass;
  logic [1:0]  systemClockSource;
  logic [3:0]  divEn;
  int          errorCnt = 0;
  int          checks = 0;
  int          n[4];
  assign divEn = {rfCtrlClkEn, linkCoreClkEn, timerZeroClkEn, spiClkEn};

  periph_radio_sysclk_ctrl u_periph_radio_sysclk_ctrl (.ref_clk, .nrst, .regAddr, .regWrData, .regWrStrobe,
    .regRdStrobe, .regRdData, .crystalSettledPin, .crystalTrimDonePin, .sleepActivePin, .quadClkEn,
    .firstUartClkEn, .secondUartClkEn, .i2cClkEn, .spiClkEn, .wakeCaptureClkEn, .timersClkEn, .timerZeroClkEn,
    .linkCoreClkEn, .rfCtrlClkEn, .lpTimerReset, .crystalOscEn, .spikeFilterBypass, .systemClockSource);

  always #12.5 ref_clk = ~ref_clk;

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp)
    begin
      errorCnt++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int c);
    repeat (c) @(posedge ref_clk);
    #1;
  endtask
  task automatic wr(input logic [31:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    regAddr <= a;
    regWrData <= d;
    regWrStrobe <= 1'b1;
    @(posedge ref_clk);
    regWrStrobe <= 1'b0;
  endtask
  task automatic rd(input logic [31:0] a, input logic [15:0] exp);
    @(posedge ref_clk);
    regAddr <= a;
    regRdStrobe <= 1'b1;
    @(posedge ref_clk);
    regRdStrobe <= 1'b0;
    #1;
    chk(regRdData, exp);
  endtask
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", checks, errorCnt);
    if (errorCnt == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  initial
  begin
    repeat (5) @(posedge ref_clk);
    nrst <= 1'b1;
    tick(1);
    chk({14'h0, lpTimerReset, crystalOscEn}, 16'h3);
    rd(PER, 16'h0000);
    rd(RAD, 16'h0040);
    rd(SYS, 16'h0080);
    $display("reset test finished");
    wr(PER, 16'hffff);
    rd(PER, 16'h8bfb);
    wr(RAD, 16'hffff);
    rd(RAD, 16'h00fb);
    wr(32'h5000_000c, 16'hffff);
    rd(32'h5000_000c, 16'h0000);
    rd(32'h5000_0006, 16'h0000);
    $display("reserved bit test finished");
    wr(PER, 16'h80f8);
    tick(2);
    chk({10'h0, quadClkEn, firstUartClkEn, secondUartClkEn, i2cClkEn, wakeCaptureClkEn, timersClkEn}, 16'h3f);
    wr(PER, 16'h0000);
    tick(2);
    chk({10'h0, quadClkEn, firstUartClkEn, secondUartClkEn, i2cClkEn, wakeCaptureClkEn, timersClkEn}, 16'h00);
    $display("gate test finished");
    for (int k = 0; k < 4; k++)
    begin
      wr(PER, 16'h0808 | 16'(k << 8) | 16'(k));
      wr(RAD, 16'h0088 | 16'(k << 4) | 16'(k));
      tick(3);
      n = '{default: 0};
      repeat (16)
      begin
        tick(1);
        for (int i = 0; i < 4; i++)
          n[i] += int'(divEn[i]);
      end
      for (int i = 0; i < 4; i++)
        chk(16'(n[i]), 16'(16 >> k));
    end
    chk({15'h0, lpTimerReset}, 16'h0);
    wr(PER, 16'h0000);
    wr(RAD, 16'h0000);
    tick(2);
    chk({12'h0, divEn}, 16'h0);
    $display("divider test finished");
    wr(SYS, 16'h0009);
    tick(2);
    chk({12'h0, spikeFilterBypass, crystalOscEn, systemClockSource}, 16'hd);
    rd(SYS, 16'h0049);
    wr(SYS, 16'h0006);
    tick(2);
    chk({14'h0, crystalOscEn, systemClockSource[1]}, 16'h1);
    rd(SYS, 16'h0026);
    wr(SYS, 16'h0007);
    tick(2);
    chk({14'h0, systemClockSource}, 16'h2);
    rd(SYS, 16'h0027);
    @(posedge ref_clk);
    sleepActivePin <= 1'b1;
    tick(8);
    @(posedge ref_clk);
    sleepActivePin <= 1'b0;
    tick(8);
    chk({15'h0, crystalOscEn}, 16'h0);
    wr(SYS, 16'h0003);
    tick(8);
    chk({15'h0, crystalOscEn}, 16'h1);
    wr(SYS, 16'h0000);
    tick(8);
    chk({14'h0, systemClockSource}, 16'h2);
    rd(SYS, 16'h0000);
    @(posedge ref_clk);
    crystalTrimDonePin <= 1'b1;
    tick(8);
    chk({14'h0, systemClockSource}, 16'h0);
    rd(SYS, 16'h0080);
    $display("system clock test finished");
    report_and_stop();
  end

  initial
  begin
    repeat (3000) @(posedge ref_clk);
    errorCnt++;
    report_and_stop();
  end
endmodule

bind periph_radio_sysclk_ctrl periph_radio_sysclk_ctrl_chk #(.ADDR_WIDTH(ADDR_WIDTH), .DATA_WIDTH(DATA_WIDTH))
  u_periph_radio_sysclk_ctrl_chk (.ref_clk, .nrst, .regAddr, .regWrData, .regWrStrobe, .regRdStrobe, .regRdData,
  .quadClkEn, .firstUartClkEn, .secondUartClkEn, .i2cClkEn, .spiClkEn, .wakeCaptureClkEn, .timersClkEn,
  .timerZeroClkEn, .linkCoreClkEn, .rfCtrlClkEn, .lpTimerReset, .crystalOscEn, .spikeFilterBypass,
  .systemClockSource);
